// File: pkg/oad_pkg.sv
// Constants, field layouts and encodings for the operand address decoder
// ==========================================================================
package oad_pkg;

    // ======================================================================
    // Addressing-form byte layout
    localparam int MODRM_MOD_MSB = 7;              // Form field upper bit
    localparam int MODRM_MOD_LSB = 6;              // Form field lower bit
    localparam int MODRM_RM_MSB  = 2;              // Selector upper bit
    localparam int MODRM_RM_LSB  = 0;              // Selector lower bit

    // ======================================================================
    // Addressing forms
    localparam logic [1:0] MOD_NODISP = 2'h0;      // No displacement
    localparam logic [1:0] MOD_DISP8  = 2'h1;      // One byte, sign-extended
    localparam logic [1:0] MOD_DISP16 = 2'h2;      // Two bytes
    localparam logic [1:0] MOD_REG    = 2'h3;      // Register operand

    // ======================================================================
    // Operand selector codes
    localparam logic [2:0] RM_BW_SI = 3'h0;        // Base word + source index
    localparam logic [2:0] RM_BW_DST = 3'h1;       // Base word + dest index
    localparam logic [2:0] RM_FB_SI = 3'h2;        // Frame base + source index
    localparam logic [2:0] RM_FB_DST = 3'h3;       // Frame base + dest index
    localparam logic [2:0] RM_SI    = 3'h4;        // Source index
    localparam logic [2:0] RM_DST   = 3'h5;        // Dest index
    localparam logic [2:0] RM_FB    = 3'h6;        // Frame base, or direct
    localparam logic [2:0] RM_BW    = 3'h7;        // Base word

    // ======================================================================
    // Segment register codes, same as the prefix field
    localparam logic [1:0] SEG_EXTRA = 2'h0;       // Extra segment
    localparam logic [1:0] SEG_CODE  = 2'h1;       // Code segment
    localparam logic [1:0] SEG_STACK = 2'h2;       // Stack segment
    localparam logic [1:0] SEG_DATA  = 2'h3;       // Data segment

    // ======================================================================
    // Override prefix pattern 001xx110
    localparam logic [7:0] PREFIX_MASK  = 8'hE7;   // Fixed bits
    localparam logic [7:0] PREFIX_MATCH = 8'h26;   // Fixed bit values
    localparam int         PREFIX_SEG_MSB = 4;     // Segment field upper bit
    localparam int         PREFIX_SEG_LSB = 3;     // Segment field lower bit

    // ======================================================================
    // Displacement byte counts
    localparam logic [1:0] DISP_NONE = 2'h0;       // No bytes
    localparam logic [1:0] DISP_ONE  = 2'h1;       // Low byte only
    localparam logic [1:0] DISP_TWO  = 2'h2;       // Low then high

    // ======================================================================
    // Timing
    localparam int         OFS_CALC_CYCLES = 4;    // Offset calculation clocks
    localparam logic [2:0] OFS_CALC_LAST   = 3'(OFS_CALC_CYCLES - 1);

    // ======================================================================
    // Reset values
    localparam logic [15:0] OFFSET_RST = 16'h0000; // Offset after reset
    localparam logic [7:0]  BYTE_RST   = 8'h00;    // Byte latch after reset

endpackage

// File: src/oad_disp_fetch.sv
// Displacement byte collector for the operand address decoder
`timescale 1ns/1ps
module oad_disp_fetch (
    input  wire logic        i_mclk,        // Processor clock
    input  wire logic        i_sys_rst,     // Synchronous reset, high
    input  wire logic        i_ce,          // Clock enable
    input  wire logic        i_load,        // Start collecting
    input  wire logic [1:0]  i_count,       // Bytes to collect, 1 or 2
    input  wire logic        i_byte_valid,  // Stream byte present
    input  wire logic [7:0]  i_byte,        // Stream byte
    output logic             o_req,         // Wants a byte
    output logic             o_done,        // Displacement complete, pulse
    output logic [15:0]      o_disp         // Assembled displacement
);

    // ======================================================================
    // State
    logic [1:0]  left_r;                    // Bytes still expected
    logic [1:0]  left_nxt;
    logic        two_r;                     // Two-byte form
    logic        two_nxt;
    logic [7:0]  low_r;                     // First fetched byte
    logic [7:0]  low_nxt;
    logic        done_r;                    // Completion pulse
    logic        done_nxt;
    logic [15:0] disp_r;                    // Result
    logic [15:0] disp_nxt;
    logic        req_r;                     // Registered byte request
    logic        req_nxt;

    // Next-state computation
    always_comb begin
        left_nxt = left_r;
        two_nxt  = two_r;
        low_nxt  = low_r;
        done_nxt = 1'b0;
        disp_nxt = disp_r;
        if (i_load) begin
            left_nxt = i_count;
            two_nxt  = (i_count == oad_pkg::DISP_TWO);
        end else if (left_r != oad_pkg::DISP_NONE && i_byte_valid) begin
            left_nxt = left_r - 2'h1;
            if (left_r == oad_pkg::DISP_ONE) begin
                done_nxt = 1'b1;
                if (two_r) begin
                    disp_nxt = {i_byte, low_r};
                end else begin
                    disp_nxt = {{8{i_byte[7]}}, i_byte};
                end
            end else begin
                low_nxt = i_byte;           // First byte is the low half
            end
        end
        req_nxt  = (left_nxt != oad_pkg::DISP_NONE);
    end

    // Register stage, frozen while the enable is low
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            left_r <= oad_pkg::DISP_NONE;
            two_r  <= 1'b0;
            low_r  <= oad_pkg::BYTE_RST;
            done_r <= 1'b0;
            disp_r <= oad_pkg::OFFSET_RST;
            req_r  <= 1'b0;
        end else if (i_ce) begin
            left_r <= left_nxt;
            two_r  <= two_nxt;
            low_r  <= low_nxt;
            done_r <= done_nxt;
            disp_r <= disp_nxt;
            req_r  <= req_nxt;
        end
    end

    assign o_req  = req_r;
    assign o_done = done_r;
    assign o_disp = disp_r;

endmodule // oad_disp_fetch

// File: src/oad_decoder.sv
// Operand address decoder: form decode, displacement, offset and segment
`timescale 1ns/1ps
module oad_decoder (
    input  wire logic        i_mclk,                 // Processor clock
    input  wire logic        i_sys_rst,              // Synchronous reset, high
    input  wire logic        i_ce,                   // Clock enable
    input  wire logic        i_prefix_valid,         // Prefix candidate byte strobe
    input  wire logic [7:0]  i_prefix_byte,          // Prefix candidate byte
    input  wire logic        i_start,                // Addressing byte strobe
    input  wire logic [7:0]  i_modrm,                // Addressing-form byte
    input  wire logic        i_word,                 // Operand size flag w
    input  wire logic        i_string_dst,           // String destination operand
    input  wire logic        i_byte_valid,           // Stream byte present
    input  wire logic [7:0]  i_byte,                 // Stream byte
    input  wire logic [15:0] i_base_word_register,   // Base word value
    input  wire logic [15:0] i_frame_base_register,  // Frame base value
    input  wire logic [15:0] i_src_index_register,   // Source index value
    input  wire logic [15:0] i_dest_index_register,  // Dest index value
    output logic             o_busy,                 // Decode in progress
    output logic             o_disp_req,             // Wants a displacement byte
    output logic             o_done,                 // Result valid, pulse
    output logic             o_is_reg,               // Operand is a register
    output logic [2:0]       o_reg_word_idx,         // Word register index
    output logic             o_reg_is_byte,          // Byte-sized register
    output logic             o_reg_hi_byte,          // Upper byte of the word
    output logic [15:0]      o_effective_offset,     // Computed offset
    output logic [1:0]       o_seg_sel               // Segment register code
);

    // ======================================================================
    // Decode helpers
    // Displacement bytes needed by a form and selector
    function automatic logic [1:0] disp_bytes(input logic [1:0] md, input logic [2:0] rm);
        logic [1:0] n;
        n = oad_pkg::DISP_NONE;
        if (md == oad_pkg::MOD_DISP8) begin
            n = oad_pkg::DISP_ONE;
        end else if (md == oad_pkg::MOD_DISP16) begin
            n = oad_pkg::DISP_TWO;
        end else if (md == oad_pkg::MOD_NODISP && rm == oad_pkg::RM_FB) begin
            n = oad_pkg::DISP_TWO;
        end
        return n;
    endfunction

    // Frame base takes part in the offset
    function automatic logic uses_frame(input logic [1:0] md, input logic [2:0] rm);
        logic f;
        f = (rm == oad_pkg::RM_FB_SI) || (rm == oad_pkg::RM_FB_DST) ||
            (rm == oad_pkg::RM_FB && md != oad_pkg::MOD_NODISP);
        return f;
    endfunction

    // ======================================================================
    // State
    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_CALC, ST_DONE} oad_state_t;

    oad_state_t  state_r;                            // Sequencer state
    oad_state_t  state_nxt;
    logic [1:0]  mod_r;                              // Latched form
    logic [1:0]  mod_nxt;
    logic [2:0]  rm_r;                               // Latched selector
    logic [2:0]  rm_nxt;
    logic        strdst_r;                           // Latched string flag
    logic        strdst_nxt;
    logic        ovr_valid_r;                        // Override pending
    logic        ovr_valid_nxt;
    logic [1:0]  ovr_seg_r;                          // Override segment
    logic [1:0]  ovr_seg_nxt;
    logic [2:0]  calc_cnt_r;                         // Calculation clock count
    logic [2:0]  calc_cnt_nxt;
    logic [15:0] disp_r;                             // Displacement in use
    logic [15:0] disp_nxt;
    logic        busy_r;
    logic        busy_nxt;
    logic        done_r;
    logic        done_nxt;
    logic        is_reg_r;
    logic        is_reg_nxt;
    logic [2:0]  reg_idx_r;
    logic [2:0]  reg_idx_nxt;
    logic        reg_byte_r;
    logic        reg_byte_nxt;
    logic        reg_hi_r;
    logic        reg_hi_nxt;
    logic [15:0] eff_r;
    logic [15:0] eff_nxt;
    logic [1:0]  seg_r;
    logic [1:0]  seg_nxt;

    // Fetch unit wiring
    logic        fetch_load;                         // Start byte collection
    logic [1:0]  fetch_count;                        // Bytes to collect
    logic        fetch_req;                          // Collector wants bytes
    logic        fetch_done;                         // Collector finished
    logic [15:0] fetch_disp;                         // Collected displacement
    logic        prefix_hit;                         // Byte matches 001xx110

    assign prefix_hit = i_prefix_valid &&
                        ((i_prefix_byte & oad_pkg::PREFIX_MASK) == oad_pkg::PREFIX_MATCH);

    // ======================================================================
    // Displacement collector: bytes taken in stream order right after the
    // addressing byte, so immediates must not be offered until it is done
    oad_disp_fetch u_fetch (
        .i_mclk       (i_mclk),
        .i_sys_rst    (i_sys_rst),
        .i_ce         (i_ce),
        .i_load       (fetch_load),
        .i_count      (fetch_count),
        .i_byte_valid (i_byte_valid),
        .i_byte       (i_byte),
        .o_req        (fetch_req),
        .o_done       (fetch_done),
        .o_disp       (fetch_disp)
    );

    // ======================================================================
    // Sequencer and result computation
    always_comb begin
        logic [15:0] base;
        logic [1:0]  imod;
        logic [2:0]  irm;
        base          = 16'h0000;
        imod          = i_modrm[oad_pkg::MODRM_MOD_MSB:oad_pkg::MODRM_MOD_LSB];
        irm           = i_modrm[oad_pkg::MODRM_RM_MSB:oad_pkg::MODRM_RM_LSB];
        state_nxt     = state_r;
        mod_nxt       = mod_r;
        rm_nxt        = rm_r;
        strdst_nxt    = strdst_r;
        ovr_valid_nxt = ovr_valid_r;
        ovr_seg_nxt   = ovr_seg_r;
        calc_cnt_nxt  = calc_cnt_r;
        disp_nxt      = disp_r;
        busy_nxt      = busy_r;
        done_nxt      = 1'b0;
        is_reg_nxt    = is_reg_r;
        reg_idx_nxt   = reg_idx_r;
        reg_byte_nxt  = reg_byte_r;
        reg_hi_nxt    = reg_hi_r;
        eff_nxt       = eff_r;
        seg_nxt       = seg_r;
        fetch_load    = 1'b0;
        fetch_count   = disp_bytes(imod, irm);

        // Prefix latch; a new prefix outranks the end-of-instruction clear
        if (prefix_hit) begin
            ovr_valid_nxt = 1'b1;
            ovr_seg_nxt   = i_prefix_byte[oad_pkg::PREFIX_SEG_MSB:oad_pkg::PREFIX_SEG_LSB];
        end

        unique case (state_r)
            ST_IDLE: begin
                // Requests outside idle are ignored
                if (i_start) begin
                    mod_nxt    = imod;
                    rm_nxt     = irm;
                    strdst_nxt = i_string_dst;
                    busy_nxt   = 1'b1;
                    disp_nxt   = 16'h0000;
                    if (imod == oad_pkg::MOD_REG) begin
                        // Register operand, no offset formed
                        is_reg_nxt   = 1'b1;
                        reg_byte_nxt = !i_word;
                        reg_idx_nxt  = i_word ? irm : {1'b0, irm[1:0]};
                        reg_hi_nxt   = !i_word && irm[2];
                        state_nxt    = ST_DONE;
                    end else begin
                        is_reg_nxt = 1'b0;
                        if (fetch_count == oad_pkg::DISP_NONE) begin
                            state_nxt    = ST_CALC;
                            calc_cnt_nxt = 3'h0;
                        end else begin
                            fetch_load = 1'b1;
                            state_nxt  = ST_FETCH;
                        end
                    end
                end
            end
            ST_FETCH: begin
                if (fetch_done) begin
                    disp_nxt     = fetch_disp;
                    calc_cnt_nxt = 3'h0;
                    state_nxt    = ST_CALC;
                end
            end
            ST_CALC: begin
                // Fixed calculation time whatever the form
                calc_cnt_nxt = calc_cnt_r + 3'h1;
                if (calc_cnt_r == oad_pkg::OFS_CALC_LAST) begin
                    unique case (rm_r)
                        oad_pkg::RM_BW_SI: base = i_base_word_register + i_src_index_register;
                        oad_pkg::RM_BW_DST: base = i_base_word_register + i_dest_index_register;
                        oad_pkg::RM_FB_SI: base = i_frame_base_register + i_src_index_register;
                        oad_pkg::RM_FB_DST: base = i_frame_base_register + i_dest_index_register;
                        oad_pkg::RM_SI:    base = i_src_index_register;
                        oad_pkg::RM_DST:   base = i_dest_index_register;
                        oad_pkg::RM_FB:    base = (mod_r == oad_pkg::MOD_NODISP) ? 16'h0000
                                                  : i_frame_base_register;
                        oad_pkg::RM_BW:    base = i_base_word_register;
                    endcase
                    eff_nxt = base + disp_r;
                    // Segment choice, string destination first
                    if (strdst_r) begin
                        seg_nxt = oad_pkg::SEG_EXTRA;
                    end else if (ovr_valid_r) begin
                        seg_nxt = ovr_seg_r;
                    end else if (uses_frame(mod_r, rm_r)) begin
                        seg_nxt = oad_pkg::SEG_STACK;
                    end else begin
                        seg_nxt = oad_pkg::SEG_DATA;
                    end
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                // Result published; override consumed by this instruction
                done_nxt  = 1'b1;
                busy_nxt  = 1'b0;
                state_nxt = ST_IDLE;
                if (!prefix_hit) begin
                    ovr_valid_nxt = 1'b0;
                end
            end
        endcase
    end

    // Register stage, frozen while the enable is low
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            state_r     <= ST_IDLE;
            mod_r       <= oad_pkg::MOD_NODISP;
            rm_r        <= oad_pkg::RM_BW_SI;
            strdst_r    <= 1'b0;
            ovr_valid_r <= 1'b0;
            ovr_seg_r   <= oad_pkg::SEG_DATA;
            calc_cnt_r  <= 3'h0;
            disp_r      <= oad_pkg::OFFSET_RST;
            busy_r      <= 1'b0;
            done_r      <= 1'b0;
            is_reg_r    <= 1'b0;
            reg_idx_r   <= 3'h0;
            reg_byte_r  <= 1'b0;
            reg_hi_r    <= 1'b0;
            eff_r       <= oad_pkg::OFFSET_RST;
            seg_r       <= oad_pkg::SEG_DATA;
        end else if (i_ce) begin
            state_r     <= state_nxt;
            mod_r       <= mod_nxt;
            rm_r        <= rm_nxt;
            strdst_r    <= strdst_nxt;
            ovr_valid_r <= ovr_valid_nxt;
            ovr_seg_r   <= ovr_seg_nxt;
            calc_cnt_r  <= calc_cnt_nxt;
            disp_r      <= disp_nxt;
            busy_r      <= busy_nxt;
            done_r      <= done_nxt;
            is_reg_r    <= is_reg_nxt;
            reg_idx_r   <= reg_idx_nxt;
            reg_byte_r  <= reg_byte_nxt;
            reg_hi_r    <= reg_hi_nxt;
            eff_r       <= eff_nxt;
            seg_r       <= seg_nxt;
        end
    end

    // ======================================================================
    // Outputs, all from flip-flops (request comes from the collector's count)
    assign o_busy             = busy_r;
    assign o_disp_req         = fetch_req;
    assign o_done             = done_r;
    assign o_is_reg           = is_reg_r;
    assign o_reg_word_idx     = reg_idx_r;
    assign o_reg_is_byte      = reg_byte_r;
    assign o_reg_hi_byte      = reg_hi_r;
    assign o_effective_offset = eff_r;
    assign o_seg_sel          = seg_r;

endmodule // oad_decoder

// File: verification/oad_decoder_asserts.sv
// Property checker for the operand address decoder
`timescale 1ns/1ps
module oad_decoder_asserts (
    input wire logic        i_mclk,
    input wire logic        i_sys_rst,
    input wire logic        i_ce,
    input wire logic        i_start,
    input wire logic [7:0]  i_modrm,
    input wire logic        i_word,
    input wire logic        i_string_dst,
    input wire logic        i_byte_valid,
    input wire logic        o_busy,
    input wire logic        o_disp_req,
    input wire logic        o_done,
    input wire logic        o_is_reg,
    input wire logic [2:0]  o_reg_word_idx,
    input wire logic        o_reg_is_byte,
    input wire logic        o_reg_hi_byte,
    input wire logic [15:0] o_effective_offset,
    input wire logic [1:0]  o_seg_sel
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    // =========
    // Request capture, so results can be tied to their cause
    logic       take;     // Request accepted this edge
    logic [4:0] cap_r;    // String flag, word flag, selector
    logic [4:0] cap_nxt;
    assign take = i_ce && i_start && !o_busy;
    always_comb begin
        cap_nxt = take ? {i_string_dst, i_word, i_modrm[2:0]} : cap_r;
    end
    always_ff @(posedge i_mclk) begin
        cap_r <= cap_nxt;
    end
    // =========
    // Request shapes
    sequence take_reg_s; take && i_modrm[7:6] == 2'h3; endsequence
    sequence take_two_s; take && (i_modrm[7:6] == 2'h2 || i_modrm[7:0] ==? 8'b00???110); endsequence
    sequence byte_s; o_disp_req && i_byte_valid && i_ce; endsequence
    reg_latency_a:
    assert property (take_reg_s |=> !o_done ##1 (o_done && o_is_reg)) else $error("register result late");
    nodisp_time_a:
    assert property (take && i_modrm[7:6] == 2'h0 && i_modrm[2:0] != 3'h6
        |=> (o_busy && !o_disp_req)[*5] ##1 (o_done && !o_is_reg)) else $error("no-displacement timing wrong");
    disp_one_a:
    assert property (take && i_modrm[7:6] == 2'h1 ##1 byte_s |=> !o_disp_req ##6 o_done)
        else $error("one byte displacement wrong");
    disp_two_a:
    assert property (take_two_s ##1 byte_s ##1 byte_s |=> !o_disp_req ##6 o_done)
        else $error("two byte displacement wrong");
    disp_first_a:
    assert property (take && i_modrm[7:6] inside {2'h1, 2'h2} |=> o_disp_req) else $error("displacement not wanted");
    done_busy_a:
    assert property (o_done |-> !o_busy && $past(o_busy)) else $error("busy and done overlap");
    reg_decode_a:
    assert property (o_done && o_is_reg |-> o_reg_is_byte == !cap_r[3] && o_reg_hi_byte == (!cap_r[3] && cap_r[2])
        && o_reg_word_idx == (cap_r[3] ? cap_r[2:0] : {1'b0, cap_r[1:0]})) else $error("register decode wrong");
    str_seg_a:
    assert property (o_done && !o_is_reg && cap_r[4] |-> o_seg_sel == 2'h0) else $error("string segment wrong");
    reset_val_a:
    assert property ($fell(i_sys_rst) |-> o_seg_sel == 2'h3 && !o_busy && !o_done) else $error("reset values wrong");
    ce_hold_a:
    assert property (!i_ce |=> $stable(o_done) && $stable(o_effective_offset) && $stable(o_seg_sel))
        else $error("state moved without enable");
endmodule // oad_decoder_asserts
bind oad_decoder oad_decoder_asserts u_chk (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
    .i_start(i_start), .i_modrm(i_modrm), .i_word(i_word), .i_string_dst(i_string_dst),
    .i_byte_valid(i_byte_valid), .o_busy(o_busy), .o_disp_req(o_disp_req), .o_done(o_done),
    .o_is_reg(o_is_reg), .o_reg_word_idx(o_reg_word_idx), .o_reg_is_byte(o_reg_is_byte),
    .o_reg_hi_byte(o_reg_hi_byte), .o_effective_offset(o_effective_offset), .o_seg_sel(o_seg_sel));

// File: verification/oad_decoder_tb_top.sv
// Self-checking testbench for the operand address decoder
`timescale 1ns/1ps
module oad_decoder_tb_top;
    typedef struct packed {
        logic        is_reg;  // Register operand
        logic [4:0]  rg;      // Byte flag, upper flag, index
        logic [15:0] off;     // Offset
        logic [1:0]  seg;     // Segment code
    } oad_exp_t;
    logic        i_mclk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        i_ce = 1'b1;
    logic        i_prefix_valid = 1'b0;
    logic [7:0]  i_prefix_byte = 8'h00;
    logic        i_start = 1'b0;
    logic [7:0]  i_modrm = 8'h00;
    logic        i_word = 1'b0;
    logic        i_string_dst = 1'b0;
    logic        i_byte_valid = 1'b0;
    logic [7:0]  i_byte = 8'h00;
    logic [63:0] regs_v = 64'h0;     // Base word, frame base, source, dest
    logic        o_busy, o_disp_req, o_done, o_is_reg, o_reg_is_byte, o_reg_hi_byte;
    logic [2:0]  o_reg_word_idx;
    logic [15:0] o_effective_offset;
    logic [1:0]  o_seg_sel;
    int          err_total = 0;
    int          compares = 0;
    oad_exp_t    exp_q[$];           // Expected results, oldest first
    oad_exp_t    e_m;
    logic [15:0] last_off = 16'h0000; // Register form leaves these alone
    logic [1:0]  last_seg = 2'h3;
    int          seed_v;
    oad_decoder dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_prefix_valid(i_prefix_valid),
        .i_prefix_byte(i_prefix_byte), .i_start(i_start), .i_modrm(i_modrm), .i_word(i_word),
        .i_string_dst(i_string_dst), .i_byte_valid(i_byte_valid), .i_byte(i_byte),
        .i_base_word_register(regs_v[63:48]), .i_frame_base_register(regs_v[47:32]),
        .i_src_index_register(regs_v[31:16]), .i_dest_index_register(regs_v[15:0]), .o_busy(o_busy),
        .o_disp_req(o_disp_req), .o_done(o_done), .o_is_reg(o_is_reg), .o_reg_word_idx(o_reg_word_idx),
        .o_reg_is_byte(o_reg_is_byte), .o_reg_hi_byte(o_reg_hi_byte),
        .o_effective_offset(o_effective_offset), .o_seg_sel(o_seg_sel));
    initial forever #50 i_mclk = ~i_mclk;
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (err_total == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // =========
    // One decode: optional prefix, request, stream bytes, wait for result
    task automatic decode(input logic [7:0] mr, input logic w, input logic st, input logic [7:0] pb);
        logic [15:0] d, b, f, s, x, o;
        oad_exp_t e;
        int nb, k, n;
        {b, f, s, x, d} = {16'($urandom), 16'($urandom), 16'($urandom), 16'($urandom), 16'($urandom)};
        nb = (mr[7:6] == 2'h1) ? 1 : (mr[7:6] == 2'h2 || mr ==? 8'b00???110) ? 2 : 0;
        if (nb == 0) d = 16'h0000;
        if (nb == 1) d = {{8{d[7]}}, d[7:0]};
        case (mr[2:0])
            3'h0: o = b + s;
            3'h1: o = b + x;
            3'h2: o = f + s;
            3'h3: o = f + x;
            3'h4: o = s;
            3'h5: o = x;
            3'h6: o = (mr[7:6] == 2'h0) ? 16'h0000 : f;
            default: o = b;
        endcase
        if (st) e.seg = 2'h0;
        else if ((pb & 8'hE7) == 8'h26) e.seg = pb[4:3];
        else if (mr[2:1] == 2'h1 || mr[2:0] == 3'h6 && mr[7:6] != 2'h0) e.seg = 2'h2;
        else e.seg = 2'h3;
        e.is_reg = (mr[7:6] == 2'h3);
        e.rg = {!w, !w && mr[2], w ? mr[2:0] : {1'b0, mr[1:0]}};
        e.off = e.is_reg ? last_off : o + d;
        e.seg = e.is_reg ? last_seg : e.seg;
        {last_off, last_seg} = {e.off, e.seg};
        @(posedge i_mclk);
        i_prefix_valid <= 1'b1;
        i_prefix_byte <= pb;
        @(posedge i_mclk);
        i_prefix_valid <= 1'b0;
        regs_v <= {b, f, s, x};
        {i_start, i_modrm, i_word, i_string_dst} <= {1'b1, mr, w, st};
        exp_q.push_back(e);
        @(posedge i_mclk);
        i_modrm <= ~mr; // Second request while busy is ignored
        {k, n} = {0, 0};
        do begin
            i_byte_valid <= (k < nb) ? ($urandom_range(3) != 0) : 1'($urandom);
            i_byte <= (k == 0) ? d[7:0] : (k == 1) ? d[15:8] : 8'($urandom);
            @(posedge i_mclk);
            i_start <= 1'b0;
            if (i_byte_valid && o_disp_req) k++;
            n++;
        end while (o_done !== 1'b1 && n < 60);
        i_byte_valid <= 1'b0;
        if (n >= 60) check("done wait", 16'h0000, 16'h0001);
    endtask
    // =========
    // Result watcher
    always @(posedge i_mclk) begin
        if (o_done === 1'b1) begin
            if (exp_q.size() == 0) check("spare result", 16'h0001, 16'h0000);
            else begin
                e_m = exp_q.pop_front();
                check("operand kind", 16'(o_is_reg), 16'(e_m.is_reg));
                check("offset", o_effective_offset, e_m.off);
                check("segment", 16'(o_seg_sel), 16'(e_m.seg));
                if (e_m.is_reg) check("register", 16'({o_reg_is_byte, o_reg_hi_byte, o_reg_word_idx}), 16'(e_m.rg));
            end
        end
    end
    initial begin
        #(20000 * 100);
        err_total++;
        complete_run();
    end
    // =========
    // Main sequence: every form and selector, then random traffic
    initial begin
        logic [7:0] mr;
        seed_v = $urandom(32'hDED1742B);
        repeat (5) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        for (int i = 0; i < 160; i++) begin
            mr = (i < 64) ? {i[5:4], 3'($urandom), i[2:0]} : 8'($urandom);
            if (i == 70) begin
                @(posedge i_mclk);
                i_ce <= 1'b0;
                repeat (3) @(posedge i_mclk);
                i_ce <= 1'b1;
            end
            if (i == 100) begin
                @(posedge i_mclk);
                i_sys_rst <= 1'b1;
                repeat (2) @(posedge i_mclk);
                i_sys_rst <= 1'b0;
                {last_off, last_seg, mr[7:6]} = {16'h0000, 2'h3, 2'h3};
            end
            decode(mr, (i < 64) ? i[3] : 1'($urandom), mr[7:6] != 2'h3 && $urandom_range(3) == 0,
                $urandom_range(1) ? {3'h1, 2'($urandom), 3'h6} : 8'($urandom));
        end
        @(posedge i_mclk);
        complete_run();
    end
endmodule // oad_decoder_tb_top
